// file: txcfg_pkg.sv
// Constants, field layout and helpers for the transmit configuration block.
// Assumes a 32-bit AHB-Lite register bus and one 200 MHz system clock.
package txcfg_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [31:0] CFG_OFFSET       = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET    = 32'h0000_0004;
  localparam logic [31:0] ADDR_DECODE_MASK = 32'h0000_0fff;

  // ==========================================================================
  // Transmit configuration word layout
  localparam int          CFG_WIDTH      = 16;
  localparam logic [15:0] CFG_RESET      = 16'h9800;
  localparam logic [6:0]  CMD_CODE       = 7'h4c;
  localparam int          CMD_MSB        = 15;
  localparam int          CMD_LSB        = 9;
  localparam int          POL_BIT        = 8;
  localparam int          DEV_MSB        = 7;
  localparam int          DEV_LSB        = 4;
  localparam int          RSVD_BIT       = 3;
  localparam int          PWR_MSB        = 2;
  localparam int          PWR_LSB        = 0;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hfff7;

  // ==========================================================================
  // Status register layout
  localparam int STS_REJECT_BIT = 0;
  localparam int STS_UPPER_BIT  = 1;
  localparam int STS_DEV_LSB    = 8;
  localparam int STS_DEV_MSB    = 15;

  // ==========================================================================
  // Deviation decode: each code step adds one step of this size.
  localparam logic [7:0] DEV_STEP_KHZ = 8'h0f;
  localparam logic [7:0] DEV_CODE_ONE = 8'h01;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  function automatic logic [7:0] dev_khz(input logic [3:0] code);
    logic [7:0] wide;
    wide = {4'h0, code} + DEV_CODE_ONE;
    return 8'(wide * DEV_STEP_KHZ);
  endfunction : dev_khz

endpackage : txcfg_pkg

// file: bit_sync.sv
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the input is a slow level; short glitches may be lost.
`timescale 1ns/100ps
module bit_sync (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  // ==========================================================================
  // Synchroniser
  logic stage1_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_r <= 1'b0;
      syncOut  <= 1'b0;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : bit_sync

// file: transmit_config_register.sv
// Transmit configuration register with FSK channel and deviation decode.
// Assumes an AHB-Lite master with single word transfers and a data pin that
// is asynchronous to sys_clk.
// hreadyout never drops: every transfer completes with zero wait states.
//
// Functional notes
// - A word updates the configuration only if bits 15:9 hold 1001100b.
// - Polarity 1 sends data 0 on the upper channel, data 1 on the lower.
// - Polarity 0 sends data 0 on the lower channel, data 1 on the upper.
// - After reset the configuration word reads 0x9800.
// - The deviation code decodes to kHz: 1111 gives 240, 1100 gives 195.
// - Bits 7 to 4 select the deviation applied to both data values.
`timescale 1ns/100ps
module transmit_config_register (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        txData,
  output logic             channelUpper,
  output logic             fskPolaritySelect,
  output logic      [3:0]  fskDeviationSelect,
  output logic      [7:0]  deviationKhz,
  output logic      [2:0]  outputPowerSelect
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] cfg;
    logic        rejected;
    logic        upper;
    logic [7:0]  devKhz;
    logic [31:0] rdata;
    logic        ready;
    logic        wrCfg;
    logic        wrSts;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic        dataSync;
  logic        addrPhase;
  logic [31:0] offset;
  logic        selCfg;
  logic        selSts;
  logic [15:0] wordIn;
  logic        codeOk;
  logic [31:0] statusWord;

  // ==========================================================================
  // Data pin synchroniser
  bit_sync u_data_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn (txData),
    .syncOut (dataSync)
  );

  // ==========================================================================
  // Bus decode
  assign addrPhase = hsel && hready && (htrans == txcfg_pkg::HTRANS_NONSEQ);
  assign offset    = haddr & txcfg_pkg::ADDR_DECODE_MASK;
  assign selCfg    = (offset == txcfg_pkg::CFG_OFFSET);
  assign selSts    = (offset == txcfg_pkg::STATUS_OFFSET);
  assign wordIn    = hwdata[15:0];
  assign codeOk    = wordIn[txcfg_pkg::CMD_MSB:txcfg_pkg::CMD_LSB]
                     == txcfg_pkg::CMD_CODE;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.ready = 1'b1;
    st_nxt.wrCfg = 1'b0;
    st_nxt.wrSts = 1'b0;

    // Writes complete in their data phase, one cycle after the address.
    if (st_r.wrCfg)
    begin
      if (codeOk)
      begin
        st_nxt.cfg = wordIn & txcfg_pkg::CFG_WRITE_MASK;
      end
    end

    // A refused word in the same cycle as a clear keeps the flag set.
    if (st_r.wrSts && hwdata[txcfg_pkg::STS_REJECT_BIT])
    begin
      st_nxt.rejected = 1'b0;
    end
    if (st_r.wrCfg && !codeOk)
    begin
      st_nxt.rejected = 1'b1;
    end

    // Polarity 1 inverts the mapping of data onto the channel pair.
    st_nxt.upper  = dataSync ^ st_r.cfg[txcfg_pkg::POL_BIT];
    st_nxt.devKhz = txcfg_pkg::dev_khz(
                      st_r.cfg[txcfg_pkg::DEV_MSB:txcfg_pkg::DEV_LSB]
                    );

    statusWord = 32'h0000_0000;
    statusWord[txcfg_pkg::STS_REJECT_BIT] = st_nxt.rejected;
    statusWord[txcfg_pkg::STS_UPPER_BIT]  = st_r.upper;
    statusWord[txcfg_pkg::STS_DEV_MSB:txcfg_pkg::STS_DEV_LSB] = st_r.devKhz;

    // Read data is taken from the post-write value so a read right behind
    // a write to the same register sees the new word.
    if (addrPhase)
    begin
      st_nxt.wrCfg = hwrite && selCfg;
      st_nxt.wrSts = hwrite && selSts;
      if (!hwrite)
      begin
        if (selCfg)
        begin
          st_nxt.rdata = {16'h0000, st_nxt.cfg};
        end
        else if (selSts)
        begin
          st_nxt.rdata = statusWord;
        end
        else
        begin
          st_nxt.rdata = 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r.cfg      <= txcfg_pkg::CFG_RESET;
      st_r.rejected <= 1'b0;
      st_r.upper    <= 1'b0;
      // Code zero decodes to a single deviation step.
      st_r.devKhz   <= txcfg_pkg::DEV_STEP_KHZ;
      st_r.rdata    <= 32'h0000_0000;
      st_r.ready    <= 1'b1;
      st_r.wrCfg    <= 1'b0;
      st_r.wrSts    <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata             = st_r.rdata;
  assign hreadyout          = st_r.ready;
  assign hresp              = 1'b0;
  assign channelUpper       = st_r.upper;
  assign fskPolaritySelect  = st_r.cfg[txcfg_pkg::POL_BIT];
  assign fskDeviationSelect = st_r.cfg[txcfg_pkg::DEV_MSB:txcfg_pkg::DEV_LSB];
  assign deviationKhz       = st_r.devKhz;
  assign outputPowerSelect  = st_r.cfg[txcfg_pkg::PWR_MSB:txcfg_pkg::PWR_LSB];

  // ==========================================================================
  // Checks
  // Remembers whether any word was accepted since reset, so the reset
  // check knows when the stored word may legally move away from 0x9800.
  logic seenAccept_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seenAccept_r <= 1'b0;
    end
    else if (st_r.wrCfg && codeOk)
    begin
      seenAccept_r <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Rule checks

  a_reset_value: assert property (
    !seenAccept_r |-> st_r.cfg == txcfg_pkg::CFG_RESET)
    else $error("config word left its reset value without a write");

  a_code_accept: assert property (
    (st_r.wrCfg && codeOk) |=>
      st_r.cfg == ($past(hwdata[15:0]) & txcfg_pkg::CFG_WRITE_MASK))
    else $error("word with command code was not loaded");

  a_code_reject: assert property (
    (st_r.wrCfg && !codeOk) |=> $stable(st_r.cfg) && st_r.rejected)
    else $error("word without command code changed config");

  a_pol_negative: assert property (
    (st_r.cfg[txcfg_pkg::POL_BIT] && !dataSync) |=> channelUpper)
    else $error("polarity one did not put data zero on upper channel");

  a_pol_positive: assert property (
    (!st_r.cfg[txcfg_pkg::POL_BIT] && !dataSync) |=> !channelUpper)
    else $error("polarity zero did not put data zero on lower channel");

  a_dev_top: assert property (
    (fskDeviationSelect == 4'hf) ##1 (fskDeviationSelect == 4'hf)
      |-> deviationKhz == 8'hf0)
    else $error("top deviation code did not give 240 kHz");

  a_dev_follow: assert property (
    $changed(fskDeviationSelect) |=>
      deviationKhz == txcfg_pkg::dev_khz($past(fskDeviationSelect)))
    else $error("deviation did not follow its select field");

  a_rsvd_zero: assert property (
    st_r.cfg[txcfg_pkg::RSVD_BIT] == 1'b0)
    else $error("reserved bit became set");

  // The flag may only fall through a write of one to its status bit.
  a_reject_sticky: assert property (
    (st_r.rejected && !(st_r.wrSts && hwdata[txcfg_pkg::STS_REJECT_BIT]))
      |=> st_r.rejected)
    else $error("refused word flag lost");

  a_reject_clear: assert property (
    (st_r.wrSts && hwdata[txcfg_pkg::STS_REJECT_BIT] &&
     !(st_r.wrCfg && !codeOk)) |=> !st_r.rejected)
    else $error("write of one did not clear refused word flag");

  a_cfg_hold: assert property (
    !(st_r.wrCfg && codeOk) |=> $stable(st_r.cfg))
    else $error("config word changed without an accepted write");

  a_cmd_field: assert property (
    st_r.cfg[txcfg_pkg::CMD_MSB:txcfg_pkg::CMD_LSB] == txcfg_pkg::CMD_CODE)
    else $error("stored word lost its command code");

  a_pol_neg_one: assert property (
    (st_r.cfg[txcfg_pkg::POL_BIT] && dataSync) |=> !channelUpper)
    else $error("polarity one did not put data one on lower channel");

  a_pol_pos_one: assert property (
    (!st_r.cfg[txcfg_pkg::POL_BIT] && dataSync) |=> channelUpper)
    else $error("polarity zero did not put data one on upper channel");

  a_dev_195: assert property (
    (fskDeviationSelect == 4'hc) ##1 (fskDeviationSelect == 4'hc)
      |-> deviationKhz == 8'hc3)
    else $error("deviation code 1100 did not give 195 kHz");

  a_dev_range: assert property (
    deviationKhz >= txcfg_pkg::DEV_STEP_KHZ && deviationKhz <= 8'hf0)
    else $error("deviation left the decoded range");

  a_pwr_follow: assert property (
    (st_r.wrCfg && codeOk) |=> outputPowerSelect ==
      $past(hwdata[txcfg_pkg::PWR_MSB:txcfg_pkg::PWR_LSB]))
    else $error("output power select did not follow the write");

  // ==========================================================================
  // Bus checks

  a_ready_high: assert property (
    hreadyout)
    else $error("slave inserted a wait state");

  a_cfg_read: assert property (
    (addrPhase && !hwrite && selCfg) |=> hrdata == {16'h0000, st_r.cfg})
    else $error("config read returned a stale word");

  a_status_view: assert property (
    (addrPhase && !hwrite && selSts) |=>
      hrdata[txcfg_pkg::STS_DEV_MSB:txcfg_pkg::STS_DEV_LSB] ==
        $past(deviationKhz) &&
      hrdata[txcfg_pkg::STS_UPPER_BIT] == $past(channelUpper) &&
      hrdata[txcfg_pkg::STS_REJECT_BIT] == st_r.rejected)
    else $error("status read did not show the live fields");

  a_unmapped_zero: assert property (
    (addrPhase && !hwrite && !selCfg && !selSts) |=>
      hrdata == 32'h0000_0000)
    else $error("unmapped read did not return zero");

  c_accept:  cover property (st_r.wrCfg && codeOk);
  c_reject:  cover property (st_r.wrCfg && !codeOk);
  c_neg_pol: cover property (fskPolaritySelect && channelUpper);
  c_pos_pol: cover property (!fskPolaritySelect && channelUpper);
  c_dev_195: cover property (deviationKhz == 8'hc3);

endmodule : transmit_config_register

// file: ahb_host.sv
// Behavioural AHB-Lite host issuing single word transfers to one slave.
// Assumes the slave's hreadyout is fed back as hready.
`timescale 1ns/100ps
module ahb_host (
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // ==========================================================================
  // Bus cycles
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Called just after a rising edge. The released address and read-cycle hwdata are inverted so that a
  // slave reading them late cannot see the old value by chance.
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= txcfg_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~addr;
    hwdata <= wr ? wdata : ~hwdata;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rdata = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : ahb_host

// file: transmit_config_register_tb.sv
// Self-checking bench for the transmit configuration register.
// Assumes zero-wait AHB-Lite slave and a three-edge data pin path.
`timescale 1ns/100ps
module transmit_config_register_tb;
  logic        sys_clk, nrst, hsel, hwrite, hready, hresp, txData;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, outputPowerSelect;
  logic        channelUpper, fskPolaritySelect;
  logic [3:0]  fskDeviationSelect;
  logic [7:0]  deviationKhz;
  int          failures, compares;
  localparam logic [31:0] STS = 32'h0000_0004;

  ahb_host ahb_host_i (.sys_clk(sys_clk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  transmit_config_register transmit_config_register_i (.sys_clk(sys_clk),
    .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .txData(txData),
    .channelUpper(channelUpper), .fskPolaritySelect(fskPolaritySelect),
    .fskDeviationSelect(fskDeviationSelect), .deviationKhz(deviationKhz),
    .outputPowerSelect(outputPowerSelect));

  // ==========================================================================
  // Checking
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb_host_i.xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb_host_i.xfer(1'b0, a, 32'h0000_0000, r);
    chk("hrdata", exp, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd

  // Deviation in kHz is recomputed here as 15 per step, with code zero counted as one step.
  task automatic pins(input logic up, input logic pol, input logic [3:0] dev,
                      input logic [2:0] pwr);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("channelUpper", {31'h0, up}, {31'h0, channelUpper});
    chk("polarity", {31'h0, pol}, {31'h0, fskPolaritySelect});
    chk("deviation", {28'h0, dev}, {28'h0, fskDeviationSelect});
    chk("khz", (dev + 32'h1) * 32'hf, {24'h0, deviationKhz});
    chk("power", {29'h0, pwr}, {29'h0, outputPowerSelect});
    @(posedge sys_clk);
  endtask : pins

  task automatic print_verdict;
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Clock, watchdog and tests
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end

  initial
  begin
    nrst = 1'b0;
    txData = 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(32'h0, 32'h0000_9800);
    pins(1'b0, 1'b0, 4'h0, 3'h0);
    wr(32'h0, 32'h0000_99fd);
    rd(32'h0, 32'h0000_99f5);
    pins(1'b1, 1'b1, 4'hf, 3'h5);
    wr(32'h0, 32'h0000_d800);
    rd(32'h0, 32'h0000_99f5);
    rd(STS, 32'h0000_f003);
    wr(STS, 32'h0000_0001);
    rd(STS, 32'h0000_f002);
    wr(32'h8, 32'h0000_9800);
    rd(32'h10, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      wr(32'h0, {16'h0, 7'h4c, 1'b0, 4'(c), 4'h3});
      pins(1'b0, 1'b0, 4'(c), 3'h3);
    end
    for (int p = 0; p < 2; p++)
      for (int d = 0; d < 2; d++)
      begin
        txData <= d[0];
        wr(32'h0, {16'h0, 7'h4c, p[0], 8'h00});
        pins(p[0] ^ d[0], p[0], 4'h0, 3'h0);
      end
    wr(32'h0, 32'h0000_d800);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(32'h0, 32'h0000_9800);
    pins(1'b1, 1'b0, 4'h0, 3'h0);
    rd(STS, 32'h0000_0f02);
    print_verdict();
  end
endmodule : transmit_config_register_tb
